// ### ics_cfg.svh
// Purpose: constants of the instruction cycle sequencer
// Assumes: included by its bare name
// Notes:   9-bit file addresses are {bank[1:0], offset[6:0]}
`ifndef ICS_CFG_SVH
`define ICS_CFG_SVH

// ----------------------------------------------------------------
// register indices (file addresses, run control and core state are 10-bit bus word indices; byte address is four times)
// ----------------------------------------------------------------
`define ICS_IDX_INDIRECT_ACCESS_WINDOW     9'h080
`define ICS_IDX_PROGRAM_COUNTER_LOW        9'h082
`define ICS_IDX_CORE_STATUS_FLAGS          9'h083
`define ICS_IDX_INDIRECT_POINTER           9'h084
`define ICS_IDX_PROGRAM_COUNTER_HIGH_LATCH 9'h08A
`define ICS_IDX_INTERRUPT_CONTROL_FLAGS    9'h08B
`define ICS_IDX_POWER_CONTROL_FLAGS        9'h08E
`define ICS_IDX_RUN_CONTROL                10'h200
`define ICS_IDX_CORE_STATE                 10'h201

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define ICS_STATUS_RST      8'h18
`define ICS_STATUS_WMASK    8'hE7
`define ICS_POWER_CONTROL_FLAGS_MASK       8'h02
`define ICS_BIT_IRP         7
`define ICS_BIT_RP1         6
`define ICS_BIT_RP0         5
`define ICS_BIT_ZERO        2
`define ICS_NOP_WORD        14'h0000

// ----------------------------------------------------------------
// data memory layout
// ----------------------------------------------------------------
`define ICS_GPR0_LO         9'h020
`define ICS_GPR0_HI         9'h07F
`define ICS_GPR1_LO         9'h0A0
`define ICS_GPR1_HI         9'h0EF
`define ICS_MIRROR_TOP      3'h7
`define ICS_RAM_B1_BASE     9'h060
`define ICS_RAM_DEPTH       176

// ----------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------
`define ICS_OPC_MOVWF       7'h01
`define ICS_OPC_CLRF        7'h03
`define ICS_OPC_MOVF        6'h08
`define ICS_OPC_MOVLW       4'hC
`define ICS_OPC_CALL        3'h4
`define ICS_OPC_JUMP        3'h5

`endif

// ### ics_pkg.sv
// Purpose: types of the instruction cycle sequencer
// Assumes: nothing
// Notes:   constants live in ics_cfg.svh
package ics_pkg;

  typedef enum logic [1:0]
  {
    PH_ONE   = 2'b00,
    PH_TWO   = 2'b01,
    PH_THREE = 2'b10,
    PH_FOUR  = 2'b11
  } ics_phase_e;

  typedef enum logic [2:0]
  {
    OP_NOP   = 3'b000,
    OP_MOVWF = 3'b001,
    OP_MOVF  = 3'b010,
    OP_CLRF  = 3'b011,
    OP_MOVLW = 3'b100,
    OP_JUMP  = 3'b101
  } ics_op_e;

  typedef logic [8:0] ics_faddr_t;

  typedef struct packed
  {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ics_apb_req_s;

  typedef struct packed
  {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ics_apb_rsp_s;

endpackage : ics_pkg

// ### ics_ram.sv
// Purpose: general purpose data memory, one write and two read ports
// Assumes: index already mapped from the file address
// Notes:   contents undefined after power-up, as on the real part
`timescale 1ns/100ps
`default_nettype none
`include "ics_cfg.svh"
module ics_ram
(
  // clock
  input  wire logic       clk_i,
  input  wire logic       ce_i,
  // write port
  input  wire logic       we_i,
  input  wire logic [7:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  // read ports
  input  wire logic [7:0] raddr0_i,
  input  wire logic [7:0] raddr1_i,
  output logic      [7:0] rdata0_o,
  output logic      [7:0] rdata1_o
);

  logic [7:0] mem [`ICS_RAM_DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (ce_i && we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata0_o = mem[raddr0_i];
  assign rdata1_o = mem[raddr1_i];

endmodule : ics_ram
`default_nettype wire

// ### ics_core.sv
// Purpose: four-phase instruction cycle and banked data addressing
// Assumes: program memory answers combinationally on the same clock
// Notes:   registers reached over APB at byte address 4 * file address
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ics_cfg.svh"

module ics_core
  import ics_pkg::*;
(
  // clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  // register bus
  input  wire ics_apb_req_s  apb_i,
  output ics_apb_rsp_s       apb_o,
  // program memory
  input  wire logic [13:0]   prog_data_i,
  output logic      [12:0]   prog_addr_o,
  // sequencing state
  output logic      [3:0]    phase_o,
  output logic               flush_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ics_phase_e    phase_q;
  logic [3:0]    phase_oh_q;
  logic          run_q;
  logic [12:0]   pc_q;
  logic [12:0]   prog_addr_q;
  logic [13:0]   fetch_q;
  logic [13:0]   ir_q;
  logic          flush_q;
  logic          flush_o_q;
  logic [7:0]    w_q;
  logic [7:0]    opnd_q;
  logic [7:0]    status_q;
  logic [7:0]    fsr_q;
  logic [4:0]    program_counter_high_latch_q;
  logic [7:0]    interrupt_control_flags_q;
  logic [7:0]    power_control_flags_q;
  ics_apb_rsp_s  rsp_q;

  ics_op_e       op;
  logic          adv_q1;
  logic          adv_q2;
  logic          adv_q4;
  ics_faddr_t    core_addr;
  ics_faddr_t    apb_addr;
  ics_faddr_t    rd_addr [2];
  logic [7:0]    rd_val  [2];
  logic [7:0]    ram_rd  [2];
  logic [7:0]    result;
  logic          core_wr;
  logic          apb_acc;
  logic          apb_wr;
  logic          wr_go;
  ics_faddr_t    wr_addr;
  logic [7:0]    wr_data;
  logic          pc_load;

  assign adv_q1 = ce_i && run_q && (phase_q == PH_ONE);
  assign adv_q2 = ce_i && run_q && (phase_q == PH_TWO);
  assign adv_q4 = ce_i && run_q && (phase_q == PH_FOUR);

  // ----------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------
  function automatic ics_faddr_t resolve(input logic [1:0] bank, input logic [6:0] f,
                                         input logic irp, input logic [7:0] ptr);
    if (f == 7'h00)
      return {irp, ptr};
    return {bank, f};
  endfunction : resolve

  function automatic ics_faddr_t mirror(input ics_faddr_t a);
    if (a[8:7] != 2'b00 && a[6:4] == `ICS_MIRROR_TOP)
      return {2'b00, a[6:0]};
    return a;
  endfunction : mirror

  function automatic logic is_gpr(input ics_faddr_t a);
    return (a >= `ICS_GPR0_LO && a <= `ICS_GPR0_HI) ||
           (a >= `ICS_GPR1_LO && a <= `ICS_GPR1_HI);
  endfunction : is_gpr

  function automatic logic [7:0] ram_idx(input ics_faddr_t a);
    if (a <= `ICS_GPR0_HI)
      return 8'(a - `ICS_GPR0_LO);
    return 8'(a - `ICS_GPR1_LO + `ICS_RAM_B1_BASE);
  endfunction : ram_idx

  function automatic logic is_core_reg(input ics_faddr_t a, input ics_faddr_t idx);
    return a[6:0] == idx[6:0];
  endfunction : is_core_reg

  function automatic logic is_mapped(input ics_faddr_t a);
    return is_core_reg(a, `ICS_IDX_INDIRECT_ACCESS_WINDOW) ||
           is_core_reg(a, `ICS_IDX_PROGRAM_COUNTER_LOW) ||
           is_core_reg(a, `ICS_IDX_CORE_STATUS_FLAGS) ||
           is_core_reg(a, `ICS_IDX_INDIRECT_POINTER) ||
           is_core_reg(a, `ICS_IDX_PROGRAM_COUNTER_HIGH_LATCH) ||
           is_core_reg(a, `ICS_IDX_INTERRUPT_CONTROL_FLAGS) ||
           a == `ICS_IDX_POWER_CONTROL_FLAGS || is_gpr(a);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb
  begin
    op = OP_NOP;
    if (ir_q[13:7] == `ICS_OPC_MOVWF)
      op = OP_MOVWF;
    else if (ir_q[13:7] == `ICS_OPC_CLRF)
      op = OP_CLRF;
    else if (ir_q[13:8] == `ICS_OPC_MOVF)
      op = OP_MOVF;
    else if (ir_q[13:10] == `ICS_OPC_MOVLW)
      op = OP_MOVLW;
    else if (ir_q[13:11] == `ICS_OPC_JUMP || ir_q[13:11] == `ICS_OPC_CALL)
      op = OP_JUMP;
  end

  assign core_addr = mirror(resolve(status_q[`ICS_BIT_RP1:`ICS_BIT_RP0], ir_q[6:0],
                                    status_q[`ICS_BIT_IRP], fsr_q));
  assign apb_addr  = mirror(resolve(apb_i.paddr[10:9], apb_i.paddr[8:2],
                                    status_q[`ICS_BIT_IRP], fsr_q));
  assign rd_addr[0] = core_addr;
  assign rd_addr[1] = apb_addr;

  // ----------------------------------------------------------------
  // read ports: port 0 core operand, port 1 bus
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : g_rd
    always_comb
    begin
      rd_val[g] = 8'h00;
      if (is_core_reg(rd_addr[g], `ICS_IDX_PROGRAM_COUNTER_LOW))
        rd_val[g] = pc_q[7:0];
      else if (is_core_reg(rd_addr[g], `ICS_IDX_CORE_STATUS_FLAGS))
        rd_val[g] = status_q;
      else if (is_core_reg(rd_addr[g], `ICS_IDX_INDIRECT_POINTER))
        rd_val[g] = fsr_q;
      else if (is_core_reg(rd_addr[g], `ICS_IDX_PROGRAM_COUNTER_HIGH_LATCH))
        rd_val[g] = {3'h0, program_counter_high_latch_q};
      else if (is_core_reg(rd_addr[g], `ICS_IDX_INTERRUPT_CONTROL_FLAGS))
        rd_val[g] = interrupt_control_flags_q;
      else if (rd_addr[g] == `ICS_IDX_POWER_CONTROL_FLAGS)
        rd_val[g] = power_control_flags_q & `ICS_POWER_CONTROL_FLAGS_MASK;
      else if (is_gpr(rd_addr[g]))
        rd_val[g] = ram_rd[g];
    end
  end

  // ----------------------------------------------------------------
  // write path: core in phase four, bus in phase three
  // ----------------------------------------------------------------
  // bus writes land in phase three so they never collide with the core
  assign result  = (op == OP_MOVWF) ? w_q : (op == OP_CLRF) ? 8'h00 : opnd_q;
  assign core_wr = adv_q4 && (op == OP_MOVWF || op == OP_CLRF ||
                              (op == OP_MOVF && ir_q[7]));
  assign apb_acc = ce_i && apb_i.psel && apb_i.penable && rsp_q.pready &&
                   (phase_q == PH_THREE);
  assign apb_wr  = apb_acc && apb_i.pwrite && !apb_i.paddr[11] && !rsp_q.pslverr;
  assign wr_go   = core_wr || apb_wr;
  assign wr_addr = core_wr ? core_addr : apb_addr;
  assign wr_data = core_wr ? result : apb_i.pwdata[7:0];
  assign pc_load = wr_go && is_core_reg(wr_addr, `ICS_IDX_PROGRAM_COUNTER_LOW);

  ics_ram u_ram
  (
    .clk_i    (ref_clk_i),
    .ce_i     (ce_i),
    .we_i     (wr_go && is_gpr(wr_addr)),
    .waddr_i  (ram_idx(wr_addr)),
    .wdata_i  (wr_data),
    .raddr0_i (ram_idx(rd_addr[0])),
    .raddr1_i (ram_idx(rd_addr[1])),
    .rdata0_o (ram_rd[0]),
    .rdata1_o (ram_rd[1])
  );

  // ----------------------------------------------------------------
  // phase generator
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase_q    <= PH_ONE;
      phase_oh_q <= 4'h1;
    end
    else if (ce_i)
    begin
      case (phase_q)
        PH_ONE:   phase_q <= PH_TWO;
        PH_TWO:   phase_q <= PH_THREE;
        PH_THREE: phase_q <= PH_FOUR;
        PH_FOUR:  phase_q <= PH_ONE;
        default:  phase_q <= PH_ONE;
      endcase
      phase_oh_q <= {phase_oh_q[2:0], phase_oh_q[3]};
    end
  end

  // ----------------------------------------------------------------
  // program counter and fetch
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pc_q        <= 13'h0000;
      prog_addr_q <= 13'h0000;
    end
    else if (adv_q1)
    begin
      prog_addr_q <= pc_q;
      pc_q        <= pc_q + 13'h0001;
    end
    else if (adv_q4 && op == OP_JUMP)
    begin
      pc_q <= {program_counter_high_latch_q[4:3], ir_q[10:0]};
    end
    else if (pc_load)
    begin
      pc_q <= {program_counter_high_latch_q, wr_data};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fetch_q <= `ICS_NOP_WORD;
    else if (adv_q4)
      fetch_q <= prog_data_i;
  end

  // ----------------------------------------------------------------
  // pipeline: execute stage and flush
  // ----------------------------------------------------------------
  // a counter change discards the word fetched from the old address
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flush_q <= 1'b1;
    else if ((adv_q4 && op == OP_JUMP) || pc_load)
      flush_q <= 1'b1;
    else if (adv_q1)
      flush_q <= 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ir_q      <= `ICS_NOP_WORD;
      flush_o_q <= 1'b1;
    end
    else if (adv_q1)
    begin
      ir_q      <= flush_q ? `ICS_NOP_WORD : fetch_q;
      flush_o_q <= flush_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      opnd_q <= 8'h00;
    else if (adv_q2)
      opnd_q <= rd_val[0];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      w_q <= 8'h00;
    else if (adv_q4 && op == OP_MOVLW)
      w_q <= ir_q[7:0];
    else if (adv_q4 && op == OP_MOVF && !ir_q[7])
      w_q <= opnd_q;
  end

  // ----------------------------------------------------------------
  // core registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      status_q <= `ICS_STATUS_RST;
    else
    begin
      if (wr_go && is_core_reg(wr_addr, `ICS_IDX_CORE_STATUS_FLAGS))
        status_q <= (status_q & ~`ICS_STATUS_WMASK) | (wr_data & `ICS_STATUS_WMASK);
      // flag update follows the write, as the result of the same instruction
      if (adv_q4 && (op == OP_MOVF || op == OP_CLRF))
        status_q[`ICS_BIT_ZERO] <= (result == 8'h00);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fsr_q <= 8'h00;
    else if (wr_go && is_core_reg(wr_addr, `ICS_IDX_INDIRECT_POINTER))
      fsr_q <= wr_data;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      program_counter_high_latch_q <= 5'h00;
    else if (wr_go && is_core_reg(wr_addr, `ICS_IDX_PROGRAM_COUNTER_HIGH_LATCH))
      program_counter_high_latch_q <= wr_data[4:0];
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      interrupt_control_flags_q <= 8'h00;
    else if (wr_go && is_core_reg(wr_addr, `ICS_IDX_INTERRUPT_CONTROL_FLAGS))
      interrupt_control_flags_q <= wr_data;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      power_control_flags_q <= 8'h00;
    else if (wr_go && wr_addr == `ICS_IDX_POWER_CONTROL_FLAGS)
      power_control_flags_q <= wr_data & `ICS_POWER_CONTROL_FLAGS_MASK;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      run_q <= 1'b1;
    else if (apb_acc && apb_i.pwrite && apb_i.paddr[11:2] == `ICS_IDX_RUN_CONTROL)
      run_q <= apb_i.pwdata[0];
  end

  // ----------------------------------------------------------------
  // bus slave: answer raised at the phase-two edge
  // ----------------------------------------------------------------
  // limitation: a transfer waits up to one instruction cycle for its slot
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rsp_q <= '0;
    else if (ce_i)
    begin
      if (rsp_q.pready)
      begin
        rsp_q.pready  <= 1'b0;
        rsp_q.pslverr <= 1'b0;
        rsp_q.prdata  <= 32'h0000_0000;
      end
      else if (apb_i.psel && apb_i.penable && phase_q == PH_TWO)
      begin
        rsp_q.pready  <= 1'b1;
        rsp_q.pslverr <= 1'b0;
        rsp_q.prdata  <= 32'h0000_0000;
        if (apb_i.paddr[11:2] == `ICS_IDX_RUN_CONTROL)
          rsp_q.prdata <= {31'h0000_0000, run_q};
        else if (apb_i.paddr[11:2] == `ICS_IDX_CORE_STATE)
          rsp_q.prdata <= {3'h0, pc_q, 12'h000, flush_q, phase_q, run_q};
        else if (!apb_i.paddr[11] && is_mapped(apb_addr))
          rsp_q.prdata <= {24'h00_0000, rd_val[1]};
        else
          rsp_q.pslverr <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign apb_o       = rsp_q;
  assign prog_addr_o = prog_addr_q;
  assign phase_o     = phase_oh_q;
  assign flush_o     = flush_o_q;

endmodule : ics_core
`default_nettype wire

// ### ics_prog_mem.sv
// Purpose: program memory model facing the sequencer fetch port
// Assumes: combinational read on the core clock, contents loaded by the bench
// Notes:   words past the table read as no-operation
`timescale 1ns/100ps
`default_nettype none
module ics_prog_mem
(
  // fetch port
  input  wire logic [12:0] addr_i,
  output logic      [13:0] data_o
);
  logic [13:0] rom_words [0:31];

  // ----------------------------------------------------------------
  // read
  // ----------------------------------------------------------------
  // a runaway counter fetches a harmless word, not an unknown one
  // continuous read, so words loaded after time zero are seen at once
  assign data_o = (addr_i < 13'h0020) ? rom_words[addr_i[4:0]] : 14'h0000;
endmodule : ics_prog_mem
`default_nettype wire

// ### ics_core_assertions.sv
// Purpose: concurrent checks on the sequencer ports
// Assumes: single clock domain, async active-low reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
`include "ics_cfg.svh"
module ics_core_assertions
  import ics_pkg::*;
(
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  // register bus
  input  wire ics_apb_req_s apb_i,
  input  wire ics_apb_rsp_s apb_o,
  // program memory and state
  input  wire logic [13:0]  prog_data_i,
  input  wire logic [12:0]  prog_addr_o,
  input  wire logic [3:0]   phase_o,
  input  wire logic         flush_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  a_phase_onehot: assert property ($onehot(phase_o))
    else $error("phase not one-hot");
  a_phase_rotate: assert property (ce_i |=> phase_o == {$past(phase_o[2:0]), $past(phase_o[3])})
    else $error("phase did not advance by one");
  a_ce_freeze: assert property (!ce_i |=> $stable(phase_o) && $stable(prog_addr_o))
    else $error("state moved with clock enable low");
  a_fetch_hold: assert property ($changed(prog_addr_o) |=> $stable(prog_addr_o)[*3])
    else $error("fetch address held under one cycle");
  a_fetch_phase: assert property ($changed(prog_addr_o) |-> phase_o[0] || phase_o[1])
    else $error("fetch address moved outside phase one");
  a_flush_cycle: assert property ($rose(flush_o) |=> flush_o[*3])
    else $error("flush shorter than one instruction cycle");

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  // the answer freezes with the rest of the state while clock enable is low
  a_ready_pulse: assert property (apb_o.pready && ce_i |=> !apb_o.pready)
    else $error("pready stood more than one cycle");
  a_ready_phase: assert property (apb_o.pready |-> phase_o == 4'h4 && apb_i.psel && apb_i.penable)
    else $error("pready outside phase three or without request");
  a_ready_bound: assert property ($rose(apb_i.penable) && ce_i |-> ##[1:4] apb_o.pready)
    else $error("no bus answer within one instruction cycle");
  a_err_zero: assert property (apb_o.pslverr |-> apb_o.pready && apb_o.prdata == 32'h0)
    else $error("error answer with nonzero data");
  // core state word carries the counter in its upper half
  a_upper_zero: assert property (apb_o.pready && apb_i.paddr[11:2] != `ICS_IDX_CORE_STATE
                                 |-> apb_o.prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_state_pad: assert property (apb_o.pready && apb_i.paddr[11:2] == `ICS_IDX_CORE_STATE
                                |-> apb_o.prdata[31:29] == 3'h0 && apb_o.prdata[15:4] == 12'h000)
    else $error("core state spare bits not zero");
endmodule : ics_core_assertions

bind ics_core ics_core_assertions ics_core_assertions_inst
(
  .ref_clk_i   (ref_clk_i),
  .rst_n_i     (rst_n_i),
  .ce_i        (ce_i),
  .apb_i       (apb_i),
  .apb_o       (apb_o),
  .prog_data_i (prog_data_i),
  .prog_addr_o (prog_addr_o),
  .phase_o     (phase_o),
  .flush_o     (flush_o)
);
`default_nettype wire

// ### ics_core_bench.sv
// Purpose: self-checking bench for the instruction cycle sequencer
// Assumes: program memory model ics_prog_mem, byte address 4 * file address
// Notes:   a short program runs from reset, results read back over the bus
`timescale 1ns/100ps
`default_nettype none
module ics_core_bench
  import ics_pkg::*;
;
  localparam logic [13:0] PROG [18] = '{14'h3055, 14'h00A0, 14'h30A5, 14'h00F0, 14'h2808,
    14'h30EE, 14'h0000, 14'h0000, 14'h00A1, 14'h3022, 14'h0084, 14'h3099, 14'h0080,
    14'h3038, 14'h0083, 14'h3066, 14'h00A0, 14'h2811};
  localparam logic [12:0] FETCH [17] = '{13'h0001, 13'h0002, 13'h0003, 13'h0004, 13'h0005,
    13'h0008, 13'h0009, 13'h000A, 13'h000B, 13'h000C, 13'h000D, 13'h000E, 13'h000F,
    13'h0010, 13'h0011, 13'h0012, 13'h0011};
  localparam logic [11:0] RD_ADDR [14] = '{12'h080, 12'h3C0, 12'h5C0, 12'h7C0, 12'h084,
    12'h088, 12'h280, 12'h210, 12'h20C, 12'h228, 12'h22C, 12'h238, 12'h234, 12'hC00};
  localparam logic [7:0]  RD_DATA [14] = '{8'h55, 8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'h99, 8'h66,
    8'h22, 8'h38, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [13:0] RD_ERR = 14'h3000;

  logic         ref_clk_i;
  logic         rst_n_i;
  logic         ce_i;
  ics_apb_req_s apb_req;
  ics_apb_rsp_s apb_rsp;
  logic [13:0]  prog_data;
  logic [12:0]  prog_addr;
  logic [3:0]   phase;
  logic         flush;
  logic [12:0]  last_addr;
  logic         last_flush;
  logic [12:0]  fetch_log [$];
  int           fail_count;
  int           checks_done;
  int           run_cycles;
  int           flush_rises;
  int           rises_at_loop;
  logic [31:0]  state_word;
  logic         state_err;

  ics_core ics_core_inst
  (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .apb_i       (apb_req),
    .apb_o       (apb_rsp),
    .prog_data_i (prog_data),
    .prog_addr_o (prog_addr),
    .phase_o     (phase),
    .flush_o     (flush)
  );

  ics_prog_mem ics_prog_mem_inst
  (
    .addr_i (prog_addr),
    .data_o (prog_data)
  );

  initial ref_clk_i = 1'b0;
  always #2 ref_clk_i = ~ref_clk_i;

  // ----------------------------------------------------------------
  // fetch monitor
  // ----------------------------------------------------------------
  // spacing is only judged before the clock-enable pause
  always @(posedge ref_clk_i)
  begin
    if (rst_n_i && ce_i)
    begin
      run_cycles++;
      if (flush === 1'b1 && last_flush === 1'b0)
        flush_rises++;
      last_flush = flush;
      if (prog_addr !== last_addr)
      begin
        if (fetch_log.size() > 0 && fetch_log.size() < 16)
          check(32'(run_cycles), 32'h4, "fetch spacing");
        if (prog_addr === 13'h0011 && rises_at_loop < 0)
          rises_at_loop = flush_rises;
        fetch_log.push_back(prog_addr);
        last_addr = prog_addr;
        run_cycles = 0;
      end
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge ref_clk_i);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 40);
    check({31'h0, apb_rsp.pready}, 32'h1, "bus answer");
    rdata = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] addr, input logic [7:0] exp, input logic exp_err);
    logic [31:0] d;
    logic        e;
    apb(1'b0, addr, 32'h0, d, e);
    check(d, {24'h0, exp}, $sformatf("read %h", addr));
    check({31'h0, e}, {31'h0, exp_err}, $sformatf("error flag %h", addr));
  endtask : rd

  task automatic wr(input logic [11:0] addr, input logic [7:0] data, input logic exp_err);
    logic [31:0] d;
    logic        e;
    apb(1'b1, addr, {24'hFFFFFF, data}, d, e);
    check({31'h0, e}, {31'h0, exp_err}, $sformatf("write error %h", addr));
  endtask : wr

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    fail_count = 0;
    checks_done = 0;
    run_cycles = 0;
    flush_rises = 0;
    rises_at_loop = -1;
    last_addr = 13'h0000;
    last_flush = 1'b1;
    ce_i = 1'b1;
    rst_n_i = 1'b0;
    apb_req = '0;
    for (int i = 0; i < 32; i++)
      ics_prog_mem_inst.rom_words[i] = (i < 18) ? PROG[i] : 14'h0000;
    repeat (20) @(posedge ref_clk_i);
    check({28'h0, phase}, 32'h1, "phase in reset");
    check({19'h0, prog_addr}, 32'h0, "fetch address in reset");
    rst_n_i <= 1'b1;
    for (int n = 0; n < 400 && fetch_log.size() < 17; n++)
      @(posedge ref_clk_i);
    for (int i = 0; i < 17; i++)
      check({19'h0, fetch_log[i]}, {19'h0, FETCH[i]}, "fetch order");
    check(32'(rises_at_loop), 32'h1, "flush count");
    @(posedge ref_clk_i);
    ce_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    ce_i <= 1'b1;
    for (int i = 0; i < 14; i++)
      rd(RD_ADDR[i], RD_DATA[i], RD_ERR[i]);
    wr(12'h210, 8'h23, 1'b0);
    wr(12'h200, 8'h77, 1'b0);
    rd(12'h08C, 8'h77, 1'b0);
    rd(12'h200, 8'h77, 1'b0);
    wr(12'h22C, 8'h5A, 1'b0);
    rd(12'h22C, 8'h5A, 1'b0);
    wr(12'h234, 8'hFF, 1'b1);
    rd(12'h234, 8'h00, 1'b1);
    wr(12'h800, 8'h00, 1'b0);
    rd(12'h800, 8'h00, 1'b0);
    wr(12'h800, 8'h01, 1'b0);
    rd(12'h800, 8'h01, 1'b0);
    apb(1'b0, 12'h804, 32'h0, state_word, state_err);
    check({29'h0, state_word[2:0]}, 32'h3, "core state phase and run");
    check({31'h0, state_err}, 32'h0, "core state error");
    end_sim();
  end

  initial
  begin
    #80000;
    fail_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : ics_core_bench
`default_nettype wire
